//--- design/asr_pkg.sv
/*
 * Shared constants and types for the serial result readout link.
 * Assumes a 10 MHz system clock on both ends.
 */
package asr_pkg;
    localparam int unsigned CLK_HZ         = 10_000_000;
    localparam int unsigned RES_BITS       = 12;
    localparam int unsigned CONVERSION_START_N_TIME_NS   = 14_000;
    localparam int unsigned CONVERSION_START_N_CYC       = (CONVERSION_START_N_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int unsigned IDCLK_HALF_NS  = 500;
    localparam int unsigned IDCLK_HALF_CYC = (IDCLK_HALF_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int unsigned FIRST_CLK_NS   = 1_400;
    localparam int unsigned FIRST_CLK_CYC  = (FIRST_CLK_NS * (CLK_HZ / 1_000_000)) / 1000;
    // Host half period; must cover the round trip through both ends' synchronisers
    localparam int unsigned HOST_HALF_CYC  = 8;
    localparam logic [11:0] RESULT_RST     = 12'h000;
    localparam logic [15:0] HALF_RST       = 16'h0000;

    typedef enum logic [1:0] {
        ASR_IDLE = 2'b00,
        ASR_CONVERSION_START_N = 2'b01,
        ASR_DONE = 2'b11
    } asr_conversion_start_n_state_t;
endpackage : asr_pkg

//--- design/asr_link_if.sv
/*
 * Pins between converter readout and host serial port.
 * Resolves the two-way clock pin here from the enables; the device enable wins.
 */
`timescale 1ns/10ps
`default_nettype none
interface asr_link_if;
    logic conversion_start_n_start_n;      // Conversion start, active low
    logic busy_n;            // Busy, low during a conversion
    logic cs_n;              // Chip select, active low
    logic clock_source_select; // High: host supplies the clock
    logic sclk_dev_o;        // Device drive of serial_shift_clock
    logic sclk_dev_oe;       // Device enable on serial_shift_clock
    logic sclk_host_o;       // Host drive of serial_shift_clock
    logic sclk_host_oe;      // Host enable on serial_shift_clock
    logic sclk;              // Resolved serial_shift_clock level
    logic data;              // Serial data level
    logic data_oe;           // Device enable on data

    assign sclk = sclk_dev_oe ? sclk_dev_o : (sclk_host_oe ? sclk_host_o : 1'b0);

    modport dev  (input conversion_start_n_start_n, cs_n, clock_source_select, sclk,
                  output busy_n, sclk_dev_o, sclk_dev_oe, data, data_oe);
    modport host (input busy_n, sclk, data, data_oe,
                  output conversion_start_n_start_n, cs_n, clock_source_select, sclk_host_o, sclk_host_oe);
endinterface : asr_link_if
`default_nettype wire

//--- design/asr_device.sv
/*
 * Converter end: conversion sequencing and serial result shift-out.
 * Assumes the host end drives start, select and chip select pins.
 */
// Notes on behaviour
// - Results are signed two's complement codes.
// - Result shifts during conversion (internal) or on host clocks (external).
// - Internal mode sends previous result during conversion.
// - Internal mode: data, clock low otherwise.
// - Twelve bits MSB first, stable both edges.
// - Busy low across whole internal transfer.
// - External mode reads after, during, or both.
// - External: shift on rise, host samples fall.
// - Rising-edge sampler needs one extra period.
// - Clock high at busy rise skips load.
// - Beyond twelve clocks data goes low.
// - Shift register holds old result during conversion.
// - Host best reads between conversions, clock static.
// - Reading during conversion prefers fast clock.
// - Chip select disables outputs, gates host clock.
// - Chip select release disables outputs anytime.
// - Conversion starts even with chip select high.
// - Chip select high: internal transfer still runs.
// - Start ignored while converting.
// - Busy low from start to completion.
// - Result copied to shift register as busy rises.
`timescale 1ns/10ps
`default_nettype none
module asr_device
    import asr_pkg::*;
(
    input  wire logic        i_clk,     // System clock
    input  wire logic        i_rstn,    // Synchronous reset, active low
    input  wire logic [11:0] i_sample,  // Two's complement result from the core
    asr_link_if.dev          link,      // Pins to host
    output logic             o_conversion_start_n_done // Pulse when a result is latched
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: two flops before any logic
    logic [1:0] conversion_start_n_sync_reg;
    logic [1:0] cs_sync_reg;
    logic [1:0] sel_sync_reg;
    logic [1:0] sclk_sync_reg;
    logic       conversion_start_n_prev_reg;
    logic       sclk_prev_reg;

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            conversion_start_n_sync_reg <= 2'h3;
            cs_sync_reg   <= 2'h3;
            sel_sync_reg  <= 2'h0;
            sclk_sync_reg <= 2'h0;
            conversion_start_n_prev_reg <= 1'b1;
            sclk_prev_reg <= 1'b0;
        end
        else
        begin
            conversion_start_n_sync_reg <= {conversion_start_n_sync_reg[0], link.conversion_start_n_start_n};
            cs_sync_reg   <= {cs_sync_reg[0], link.cs_n};
            sel_sync_reg  <= {sel_sync_reg[0], link.clock_source_select};
            sclk_sync_reg <= {sclk_sync_reg[0], link.sclk};
            conversion_start_n_prev_reg <= conversion_start_n_sync_reg[1];
            sclk_prev_reg <= sclk_sync_reg[1];
        end
    end

    logic conversion_start_n_fall;
    logic cs_active;
    logic ext_mode;
    logic sclk_level;
    logic sclk_rise;
    assign conversion_start_n_fall  = conversion_start_n_prev_reg & ~conversion_start_n_sync_reg[1];
    assign cs_active  = ~cs_sync_reg[1];
    assign ext_mode   = sel_sync_reg[1];
    assign sclk_level = sclk_sync_reg[1] & cs_active;
    assign sclk_rise  = sclk_sync_reg[1] & ~sclk_prev_reg & cs_active;

    ////////////////////////////////////////////////////////////////////////
    // Conversion sequencer
    asr_conversion_start_n_state_t state_reg;
    logic [15:0]     conversion_start_n_cnt_reg;
    logic [11:0]     work_reg;

    // Starts accepted regardless of chip select, ignored mid-conversion
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            state_reg    <= ASR_IDLE;
            conversion_start_n_cnt_reg <= HALF_RST;
            work_reg     <= RESULT_RST;
        end
        else
        begin
            unique case (state_reg)
                ASR_IDLE:
                begin
                    if (conversion_start_n_fall)
                    begin
                        state_reg    <= ASR_CONVERSION_START_N;
                        conversion_start_n_cnt_reg <= HALF_RST;
                        work_reg     <= i_sample;
                    end
                end
                ASR_CONVERSION_START_N:
                begin
                    conversion_start_n_cnt_reg <= conversion_start_n_cnt_reg + 16'h0001;
                    if (conversion_start_n_cnt_reg == 16'(CONVERSION_START_N_CYC - 1))
                        state_reg <= ASR_DONE;
                end
                ASR_DONE:
                    state_reg <= ASR_IDLE;
            endcase
        end
    end

    logic load_now;
    assign load_now = (state_reg == ASR_DONE);

    // Busy low through conversion; one flop straight to the pin
    logic busy_n_reg;
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
            busy_n_reg <= 1'b1;
        else
            busy_n_reg <= ~((state_reg == ASR_IDLE && conversion_start_n_fall) ||
                            (state_reg == ASR_CONVERSION_START_N));
    end

    ////////////////////////////////////////////////////////////////////////
    // Internal serial clock generator; runs during conversion only
    logic [15:0] half_cnt_reg;
    logic [4:0]  int_bits_reg;
    logic        int_clk_reg;
    logic        int_active;
    assign int_active = (state_reg == ASR_CONVERSION_START_N) && !ext_mode
                        && (conversion_start_n_cnt_reg >= 16'(FIRST_CLK_CYC - IDCLK_HALF_CYC));

    // Sending keeps going with chip select high; only pins are masked
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn || state_reg != ASR_CONVERSION_START_N)
        begin
            half_cnt_reg <= HALF_RST;
            int_bits_reg <= 5'h00;
            int_clk_reg  <= 1'b0;
        end
        else if (int_active && int_bits_reg < 5'(RES_BITS))
        begin
            if (half_cnt_reg == 16'(IDCLK_HALF_CYC - 1))
            begin
                half_cnt_reg <= HALF_RST;
                int_clk_reg  <= ~int_clk_reg;
                if (int_clk_reg)
                    int_bits_reg <= int_bits_reg + 5'h01; // Next bit after fall
            end
            else
                half_cnt_reg <= half_cnt_reg + 16'h0001;
        end
        else
            int_clk_reg <= 1'b0;
    end

    logic int_shift;
    assign int_shift = int_active && int_clk_reg &&
                       half_cnt_reg == 16'(IDCLK_HALF_CYC - 1);

    ////////////////////////////////////////////////////////////////////////
    // Output shift register and external bit counter
    logic [11:0] shift_reg;
    logic [4:0]  ext_cnt_reg;

    // Load skipped if host clock sits high at completion
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            shift_reg   <= RESULT_RST;
            ext_cnt_reg <= 5'h00;
        end
        else if (load_now)
        begin
            if (!(ext_mode && sclk_level))
            begin
                shift_reg   <= work_reg;
                ext_cnt_reg <= 5'h00;
            end
        end
        else if (int_shift)
            shift_reg <= {shift_reg[10:0], 1'b0};
        else if (ext_mode && sclk_rise)
        begin
            // First rise presents MSB; later rises advance
            if (ext_cnt_reg != 5'h00)
                shift_reg <= {shift_reg[10:0], 1'b0};
            if (ext_cnt_reg < 5'(RES_BITS + 1))
                ext_cnt_reg <= ext_cnt_reg + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drivers from flops, masked by chip select
    logic data_reg;
    logic data_oe_reg;
    logic sclk_o_reg;
    logic sclk_oe_reg;
    logic done_reg;

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            data_reg    <= 1'b0;
            data_oe_reg <= 1'b0;
            sclk_o_reg  <= 1'b0;
            sclk_oe_reg <= 1'b0;
            done_reg    <= 1'b0;
        end
        else
        begin
            data_oe_reg <= cs_active;
            sclk_oe_reg <= cs_active && !ext_mode;
            done_reg    <= load_now;
            if (ext_mode)
            begin
                sclk_o_reg <= 1'b0;
                // Low once past the twelfth clock
                data_reg   <= (ext_cnt_reg != 5'h00 && ext_cnt_reg <= 5'(RES_BITS))
                              ? shift_reg[11] : 1'b0;
            end
            else
            begin
                sclk_o_reg <= int_clk_reg;
                // Move only once the clock pin is low, so a bit outlives the fall
                if (!sclk_o_reg && !int_clk_reg)
                    data_reg <= (int_active && int_bits_reg < 5'(RES_BITS))
                                ? shift_reg[11] : 1'b0;
            end
        end
    end

    assign link.busy_n      = busy_n_reg;
    assign link.data        = data_reg & data_oe_reg;
    assign link.data_oe     = data_oe_reg;
    assign link.sclk_dev_o  = sclk_o_reg;
    assign link.sclk_dev_oe = sclk_oe_reg;
    assign o_conversion_start_n_done      = done_reg;

endmodule : asr_device
`default_nettype wire

//--- design/asr_host.sv
/*
 * Host end: starts conversions and reads twelve-bit results.
 * Assumes the device end sits on the same interface instance.
 */
`timescale 1ns/10ps
`default_nettype none
module asr_host
    import asr_pkg::*;
(
    input  wire logic        i_clk,      // System clock
    input  wire logic        i_rstn,     // Synchronous reset, active low
    input  wire logic        i_start,    // Pulse: begin a conversion
    input  wire logic        i_ext_mode, // High: host clocks the data
    input  wire logic        i_cs_off,   // High: chip select released
    asr_link_if.host         link,       // Pins to device
    output logic [11:0]      o_result,   // Last result, signed
    output logic             o_valid     // Pulse with a new result
);

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers
    logic [1:0] busy_sync_reg;
    logic [1:0] data_sync_reg;
    logic [1:0] sclk_sync_reg;
    logic       busy_prev_reg;
    logic       sclk_prev_reg;

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            busy_sync_reg <= 2'h3;
            data_sync_reg <= 2'h0;
            sclk_sync_reg <= 2'h0;
            busy_prev_reg <= 1'b1;
            sclk_prev_reg <= 1'b0;
        end
        else
        begin
            busy_sync_reg <= {busy_sync_reg[0], link.busy_n};
            data_sync_reg <= {data_sync_reg[0], link.data};
            sclk_sync_reg <= {sclk_sync_reg[0], link.sclk};
            busy_prev_reg <= busy_sync_reg[1];
            sclk_prev_reg <= sclk_sync_reg[1];
        end
    end

    logic busy_rise;
    assign busy_rise = busy_sync_reg[1] & ~busy_prev_reg;

    ////////////////////////////////////////////////////////////////////////
    // Start pulse and external clock after completion, clock idles low
    logic        conversion_start_n_n_reg;
    logic        ext_reg;
    logic        run_reg;
    logic [3:0]  half_reg;
    logic        hclk_reg;
    logic [4:0]  edge_cnt_reg;
    logic [11:0] rx_reg;
    logic [11:0] result_reg;
    logic        valid_reg;
    logic        cs_n_reg;

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            conversion_start_n_n_reg   <= 1'b1;
            ext_reg      <= 1'b0;
            run_reg      <= 1'b0;
            half_reg     <= 4'h0;
            hclk_reg     <= 1'b0;
            edge_cnt_reg <= 5'h00;
            rx_reg       <= RESULT_RST;
            result_reg   <= RESULT_RST;
            valid_reg    <= 1'b0;
            cs_n_reg     <= 1'b0;
        end
        else
        begin
            valid_reg  <= 1'b0;
            cs_n_reg   <= i_cs_off; // Chip select follows the user's request
            conversion_start_n_n_reg <= ~(i_start & ~run_reg);
            if (i_start && !run_reg)
                ext_reg <= i_ext_mode;
            if (busy_rise && ext_reg && !run_reg)
            begin
                run_reg      <= 1'b1;
                edge_cnt_reg <= 5'h00;
                half_reg     <= 4'h0;
            end
            else if (run_reg)
            begin
                if (half_reg == 4'(HOST_HALF_CYC - 1))
                begin
                    half_reg <= 4'h0;
                    hclk_reg <= ~hclk_reg;
                    if (hclk_reg)
                    begin
                        // Falling edge: sample one bit
                        rx_reg       <= {rx_reg[10:0], data_sync_reg[1]};
                        edge_cnt_reg <= edge_cnt_reg + 5'h01;
                        if (edge_cnt_reg == 5'(RES_BITS - 1))
                        begin
                            run_reg    <= 1'b0; // Clock left low
                            result_reg <= {rx_reg[10:0], data_sync_reg[1]};
                            valid_reg  <= 1'b1;
                        end
                    end
                end
                else
                    half_reg <= half_reg + 4'h1;
            end
            else if (!ext_reg && !busy_sync_reg[1] && sclk_sync_reg[1] && !sclk_prev_reg)
                rx_reg <= {rx_reg[10:0], data_sync_reg[1]}; // Internal clock rise
            else if (!ext_reg && busy_rise)
            begin
                result_reg <= rx_reg; // Internal frame ends at busy rise
                valid_reg  <= 1'b1;
            end
        end
    end

    assign link.conversion_start_n_start_n        = conversion_start_n_n_reg;
    assign link.cs_n                = cs_n_reg;
    assign link.clock_source_select = ext_reg;
    assign link.sclk_host_o         = hclk_reg;
    assign link.sclk_host_oe        = ext_reg;
    assign o_result                 = result_reg;
    assign o_valid                  = valid_reg;

endmodule : asr_host
`default_nettype wire

//--- tb/asr_asserts.sv
/*
 * Concurrent checks on the readout link pins between the two ends.
 * Assumes one clock domain, synchronous active-low reset, host drives chip select.
 */
`timescale 1ns/10ps
`default_nettype none
module asr_asserts
    import asr_pkg::*;
(
    input wire logic i_clk,               // System clock
    input wire logic i_rstn,              // Synchronous reset, active low
    input wire logic conversion_start_n_start_n,        // Conversion start pin
    input wire logic busy_n,              // Busy pin
    input wire logic cs_n,                // Chip select pin
    input wire logic clock_source_select, // High: host clocks data
    input wire logic sclk_dev_oe,         // Device enable on shift clock
    input wire logic sclk,                // Resolved shift clock
    input wire logic data,                // Serial data
    input wire logic data_oe              // Device enable on data
);
    int unsigned low_cnt;                 // Cycles busy has been low

    ////////////////////////////////////////////////////////////////////////////////
    // Busy-low frame length, cleared while busy is high
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn || busy_n)
        begin
            low_cnt <= 0;
        end
        else
        begin
            low_cnt <= low_cnt + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin relations; device lags by a few cycles through its synchronisers
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    a_busy_span: assert property ($rose(busy_n) |->
        $past(low_cnt) >= CONVERSION_START_N_CYC - 2 && $past(low_cnt) <= CONVERSION_START_N_CYC + 20)
        else $error("busy low span out of range");
    a_busy_hold: assert property ($fell(busy_n) |-> !busy_n [*8])
        else $error("busy released early");
    a_start_busy: assert property ($fell(conversion_start_n_start_n) && busy_n && low_cnt == 0
        |-> ##[1:8] !busy_n)
        else $error("start not answered by busy");
    a_idle_low: assert property (!clock_source_select && !$past(clock_source_select, 4)
        && busy_n |-> !data && !sclk)
        else $error("internal lines not low outside frame");
    a_bit_high_stable: assert property (!clock_source_select && sclk && $past(sclk)
        |-> $stable(data))
        else $error("data moved while clock high");
    a_bit_setup: assert property (!clock_source_select && $rose(sclk) |-> $stable(data))
        else $error("data moved at clock rise");
    a_bit_hold: assert property (!clock_source_select && $fell(sclk) |-> $stable(data))
        else $error("data moved at clock fall");
    a_clk_in_frame: assert property (!clock_source_select && sclk |-> !busy_n)
        else $error("internal clock outside busy");
    a_end_quiet: assert property ($rose(busy_n) && !clock_source_select
        |-> !sclk && !data && !$past(sclk, 2))
        else $error("clock or data active at busy rise");
    a_ext_input: assert property (clock_source_select && $past(clock_source_select, 4)
        |-> !sclk_dev_oe)
        else $error("device drives clock in external mode");
    a_ext_clk_quiet: assert property (clock_source_select && !busy_n |-> !sclk)
        else $error("host clock active during conversion");
    a_outputs_on: assert property ($past(i_rstn, 4) && !cs_n && !$past(cs_n, 4)
        |-> data_oe)
        else $error("data not enabled under chip select");
    a_cs_disable: assert property (cs_n && $past(cs_n, 4)
        |-> !data_oe && !data && !sclk_dev_oe)
        else $error("outputs driven with chip select released");
endmodule : asr_asserts
`default_nettype wire

//--- tb/tb_top.sv
/*
 * Self-checking bench: device and host ends joined by one link interface.
 * Assumes 10 MHz clock; host owns chip select, start and mode pins.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import asr_pkg::*;
;
    logic        i_clk;                   // System clock
    logic        i_rstn;                  // Reset, active low
    logic [11:0] i_sample;                // Code under conversion
    logic        i_start;                 // Host start pulse
    logic        i_ext_mode;              // Host clocks data when high
    logic        i_cs_off;                // Host releases chip select
    logic [11:0] last_word = RESULT_RST;  // Word the host should hold
    logic        o_conversion_start_n_done;             // Device latch pulse
    logic [11:0] o_result;                // Host received word
    logic        o_valid;                 // Host word strobe
    logic [11:0] wire_word;               // Bits seen on the pins
    logic        sclk_q;                  // Shift clock, one cycle back
    int          conversion_start_n_cnt = 0;            // Device latch pulses
    int          bad_count = 0;           // Mismatches
    int          n_compared = 0;          // Comparisons
    logic [11:0] corners [4] = '{12'h800, 12'h7ff, 12'h000, 12'hfff};

    asr_link_if link_bus ();

    asr_device i_asr_device (.i_clk(i_clk), .i_rstn(i_rstn), .i_sample(i_sample),
                             .link(link_bus), .o_conversion_start_n_done(o_conversion_start_n_done));
    asr_host i_asr_host (.i_clk(i_clk), .i_rstn(i_rstn), .i_start(i_start),
                         .i_ext_mode(i_ext_mode), .i_cs_off(i_cs_off), .link(link_bus),
                         .o_result(o_result), .o_valid(o_valid));
    asr_asserts i_asr_asserts (.i_clk(i_clk), .i_rstn(i_rstn),
        .conversion_start_n_start_n(link_bus.conversion_start_n_start_n), .busy_n(link_bus.busy_n),
        .cs_n(link_bus.cs_n), .clock_source_select(link_bus.clock_source_select),
        .sclk_dev_oe(link_bus.sclk_dev_oe), .sclk(link_bus.sclk),
        .data(link_bus.data), .data_oe(link_bus.data_oe));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and watchdog; 16 conversions need well under 8000 cycles
    initial
    begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    initial
    begin
        repeat (20000) @(posedge i_clk);
        bad_count++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin monitor on the falling clock edge, where both ends' flops have settled;
    // internal frames captured at the clock rise, external ones at the fall
    always @(negedge i_clk)
    begin
        sclk_q <= link_bus.sclk;
        if (link_bus.sclk !== sclk_q && link_bus.sclk !== link_bus.clock_source_select)
            wire_word <= {wire_word[10:0], link_bus.data};
        if (o_conversion_start_n_done === 1'b1)
            conversion_start_n_cnt <= conversion_start_n_cnt + 1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Internal mode sends the previous word, external mode the current one
    function automatic logic [11:0] expect_word(input logic ext, input logic [11:0] prev,
                                                input logic [11:0] cur);
        return ext ? cur : prev;
    endfunction : expect_word

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out();
        if (bad_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    // One conversion; poke restarts mid-frame, which must be ignored
    // Chip select off through an internal conversion hides its transfer: host keeps old word
    task automatic run_conversion_start_n(input logic [11:0] s, input logic ext, input logic poke,
                            input logic cs_off, input logic [11:0] prev);
        logic [11:0] exp;
        int          n;
        exp = cs_off ? last_word : expect_word(ext, prev, s);
        last_word = exp;
        i_sample <= s;
        i_ext_mode <= ext;
        i_cs_off <= cs_off;
        i_start <= 1'b1;
        @(posedge i_clk);
        i_start <= 1'b0;
        n = 0;
        while (o_valid !== 1'b1 && n < 600)
        begin
            @(posedge i_clk);
            n++;
            if (poke && n == 30)
                i_start <= 1'b1;
            if (poke && n == 31)
                i_start <= 1'b0;
        end
        check({11'h000, o_valid}, 12'h001);
        repeat (3) @(posedge i_clk);
        check(o_result, exp);
        check(wire_word, exp);
        repeat (2) @(posedge i_clk);
    endtask : run_conversion_start_n

    ////////////////////////////////////////////////////////////////////////////////
    // Internal run first (reset word known), then external run
    initial
    begin
        logic [11:0] s;
        logic [11:0] prev;
        i_rstn = 1'b0;
        i_sample = 12'h000;
        i_start = 1'b0;
        i_ext_mode = 1'b0;
        i_cs_off = 1'b0;
        void'($urandom(32'h4926));
        repeat (3) @(posedge i_clk);
        i_rstn <= 1'b1;
        repeat (3) @(posedge i_clk);
        prev = RESULT_RST;
        for (int m = 0; m < 2; m++)
        begin
            for (int k = 0; k < 8; k++)
            begin
                s = (k < 4) ? corners[k] : 12'($urandom);
                run_conversion_start_n(s, m[0], k == 2, m == 0 && k == 5, prev);
                prev = s;
            end
        end
        check(12'(conversion_start_n_cnt), 12'h010);
        close_out();
    end
endmodule : tb_top
`default_nettype wire
